// ==== verilog/ssr_top.sv ====
`timescale 1ns/1ps
`include "ssr_defs.svh"

// How it works
// - four sections: two of four stages, two of five, eighteen in all
// - each five-stage section also shows its fourth stage on a tap
// - every section has its own serial input and independent data path
// - one shared shift clock input steps all eighteen stages
// - stages load and pass data only on a shift clock falling edge
// - contents hold indefinitely while the shift clock stays steady
// - on the edge a stage copies its input; otherwise it keeps its value
module ssr_top #(
  parameter int SHORT_STAGES = `SSR_SHORT_STAGES,
  parameter int LONG_STAGES = `SSR_LONG_STAGES,
  parameter int TAP_STAGE = `SSR_TAP_STAGE
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_shift_clock,
  input wire ssr_pkg::ssr_in_t i_data,
  output ssr_pkg::ssr_out_t o_stage,
  output logic o_snap_valid,
  input wire logic i_snap_ready,
  output ssr_pkg::ssr_out_t o_snap
);

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic clk_meta_q;
  logic clk_sync_q;
  logic clk_prev_q;
  ssr_pkg::ssr_in_t data_meta_q;
  ssr_pkg::ssr_in_t data_sync_q;
  logic fall;

  // shift clock pin: two flops before anything reads it
  always_ff @(posedge i_clk)
  begin
    clk_meta_q <= i_shift_clock;
    clk_sync_q <= clk_meta_q;
  end

  // last settled level, for the edge detector
  always_ff @(posedge i_clk)
  begin
    clk_prev_q <= clk_sync_q;
  end

  // serial data pins: two flops each, in step with the clock pin
  always_ff @(posedge i_clk)
  begin
    data_meta_q <= i_data;
    data_sync_q <= data_meta_q;
  end

  // one pulse per falling edge of the shared shift clock
  assign fall = clk_prev_q && !clk_sync_q;

  // ************************************************
  // shift sections
  // ************************************************
  logic [SHORT_STAGES-1:0] sec_a_q;
  logic [LONG_STAGES-1:0] sec_b_q;
  logic [SHORT_STAGES-1:0] sec_c_q;
  logic [LONG_STAGES-1:0] sec_d_q;

  // section a: no reset on stages; held unless an edge arrives
  always_ff @(posedge i_clk)
  begin
    if (fall)
    begin
      sec_a_q <= {sec_a_q[SHORT_STAGES-2:0], data_sync_q.sec_a};
    end
  end

  // section b: five stages, tap at the fourth
  always_ff @(posedge i_clk)
  begin
    if (fall)
    begin
      sec_b_q <= {sec_b_q[LONG_STAGES-2:0], data_sync_q.sec_b};
    end
  end

  // section c: four stages
  always_ff @(posedge i_clk)
  begin
    if (fall)
    begin
      sec_c_q <= {sec_c_q[SHORT_STAGES-2:0], data_sync_q.sec_c};
    end
  end

  // section d: five stages, tap at the fourth
  always_ff @(posedge i_clk)
  begin
    if (fall)
    begin
      sec_d_q <= {sec_d_q[LONG_STAGES-2:0], data_sync_q.sec_d};
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  ssr_pkg::ssr_out_t cur;
  logic shifted_q;
  logic push_q;

  always_comb
  begin
    cur.out_a = sec_a_q[SHORT_STAGES-1];
    cur.out_b = sec_b_q[LONG_STAGES-1];
    cur.tap_b = sec_b_q[TAP_STAGE-1];
    cur.out_c = sec_c_q[SHORT_STAGES-1];
    cur.out_d = sec_d_q[LONG_STAGES-1];
    cur.tap_d = sec_d_q[TAP_STAGE-1];
  end

  // registered copy follows the stages every cycle, ungated
  always_ff @(posedge i_clk)
  begin
    o_stage <= cur;
  end

  // stages move one edge after the pulse, o_stage one edge after them
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      shifted_q <= 1'b0;
    end
    else
    begin
      shifted_q <= fall;
    end
  end

  // a snapshot is offered once o_stage carries the new contents
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      push_q <= 1'b0;
    end
    else
    begin
      push_q <= shifted_q;
    end
  end

  ssr_buf #(
    .WIDTH($bits(ssr_pkg::ssr_out_t))
  ) u_buf (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_valid(push_q),
    .o_ready(),
    .i_data(o_stage),
    .o_valid(o_snap_valid),
    .i_ready(i_snap_ready),
    .o_data(o_snap)
  );

endmodule

// ==== verilog/ssr_defs.svh ====
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

`define SSR_SHORT_STAGES 4
`define SSR_LONG_STAGES 5
`define SSR_TAP_STAGE 4
`define SSR_BUF_DEPTH 2

`endif

// ==== verilog/ssr_pkg.sv ====
package ssr_pkg;

  // serial inputs of the four sections, sampled together
  typedef struct packed {
    logic sec_a;
    logic sec_b;
    logic sec_c;
    logic sec_d;
  } ssr_in_t;

  // outputs: a and c are four-stage, b and d five-stage with fourth-stage taps
  typedef struct packed {
    logic out_a;
    logic out_b;
    logic tap_b;
    logic out_c;
    logic out_d;
    logic tap_d;
  } ssr_out_t;

endpackage

// ==== verilog/ssr_buf.sv ====
`timescale 1ns/1ps
`include "ssr_defs.svh"

// two-entry valid/ready buffer carrying up to two snapshots of the outputs
module ssr_buf #(
  parameter int WIDTH = 6
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  // head_q faces the consumer; spare_q catches one push while the head is held
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] spare_q;
  logic head_valid_q;
  logic spare_valid_q;
  logic advance;

  // head empty or taken this cycle: it may be refilled
  assign advance = !head_valid_q || i_ready;
  assign o_valid = head_valid_q;
  assign o_data = head_q;
  assign o_ready = !spare_valid_q;

  always_ff @(posedge i_clk)
  begin
    if (advance)
    begin
      head_q <= spare_valid_q ? spare_q : i_data;
    end
    if (!advance && !spare_valid_q && i_valid)
    begin
      spare_q <= i_data;
    end
  end

  // a push while both entries are full is refused and lost
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      head_valid_q <= 1'b0;
      spare_valid_q <= 1'b0;
    end
    else if (advance)
    begin
      head_valid_q <= spare_valid_q || i_valid;
      spare_valid_q <= 1'b0;
    end
    else if (i_valid && !spare_valid_q)
    begin
      spare_valid_q <= 1'b1;
    end
  end

endmodule

// ==== sim/ssr_monitor.sv ====
`timescale 1ns/1ps
module ssr_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_shift_clock,
  input wire ssr_pkg::ssr_out_t o_stage,
  input wire logic o_snap_valid,
  input wire logic i_snap_ready,
  input wire ssr_pkg::ssr_out_t o_snap
);
  logic [3:0] n_q;
  logic [2:0] f_q;
  logic w;
  assign w = o_snap_valid && !i_snap_ready;
  // n_q: cycles since a fall, f_q: falls since reset
  always_ff @(posedge i_clk)
  begin
    n_q <= $fell(i_shift_clock) ? 4'h0 : n_q + {3'h0, n_q != 4'hf};
    f_q <= i_srst ? 3'h0 : f_q + {2'h0, $fell(i_shift_clock) && f_q != 3'h7};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence sh; f_q == 3'h7 && !$stable(o_stage); endsequence
  a_edge_only: assert property (sh |-> n_q inside {[2:6]})
    else $error("stage moved off edge");
  a_tap_b: assert property (sh |-> o_stage.out_b == $past(o_stage.tap_b))
    else $error("b tap not passed");
  a_tap_d: assert property (sh |-> o_stage.out_d == $past(o_stage.tap_d))
    else $error("d tap not passed");
  a_one_step: assert property (sh |=> $stable(o_stage) [*3])
    else $error("more than one step");
  a_snap_hold: assert property (w |=> o_snap_valid)
    else $error("snapshot lost");
  a_snap_data: assert property (w |=> $stable(o_snap))
    else $error("snapshot moved");
  a_snap_fresh: assert property (f_q == 3'h7 && $rose(o_snap_valid) |-> o_snap == o_stage)
    else $error("snapshot differs");
  a_no_clear: assert property (disable iff (1'b0) i_srst && n_q > 4'h6 |=> $stable(o_stage))
    else $error("stages cleared");
endmodule
bind ssr_top ssr_monitor u_mon (.i_clk, .i_srst, .i_shift_clock, .o_stage, .o_snap_valid,
  .i_snap_ready, .o_snap);

// ==== sim/ssr_feed.sv ====
`timescale 1ns/1ps
module ssr_feed (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_bits,
  output logic o_shift_clock = 1'b1,
  output ssr_pkg::ssr_in_t o_data = 4'h0,
  output logic o_busy
);
  logic [3:0] cnt_q = 4'h0;
  // data held the whole step, clock low for cycles 4 to 7
  always @(posedge i_clk)
  begin
    if (i_go && cnt_q == 4'h0) o_data <= i_bits;
    cnt_q <= cnt_q + {3'h0, i_go || cnt_q != 4'h0};
    o_shift_clock <= !(cnt_q >= 4'h4 && cnt_q < 4'h8);
  end
  assign o_busy = cnt_q != 4'h0;
endmodule

// ==== sim/ssr_top_bench.sv ====
`timescale 1ns/1ps
module ssr_top_bench;
  logic i_clk = 0, i_srst = 1, go = 0, rdy = 1, sc, busy, sv;
  logic [3:0] bits = 4'h0, ea = 4'h0, ec = 4'h0;
  logic [4:0] eb = 5'h00, ed = 5'h00;
  logic [5:0] e1, e2;
  logic [19:0] pat = 20'h3_5a9c;
  logic [17:0] hist = 18'h0_0000;
  ssr_pkg::ssr_in_t din;
  ssr_pkg::ssr_out_t st, sn;
  int err_count = 0, compares = 0, cyc = 0;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      close_out();
    end
  end
  ssr_feed u_feed (.i_clk, .i_go(go), .i_bits(bits), .o_shift_clock(sc), .o_data(din),
    .o_busy(busy));
  ssr_top DUT (.i_clk, .i_srst, .i_shift_clock(sc), .i_data(din), .o_stage(st),
    .o_snap_valid(sv), .i_snap_ready(rdy), .o_snap(sn));
  function automatic logic [5:0] ex();
    return {ea[3], eb[4], eb[3], ec[3], ed[4], ed[3]};
  endfunction
  task chk(input string n, input logic [5:0] s, input logic [5:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task shift(input logic [3:0] b);
    bits <= b;
    go <= 1;
    @(posedge i_clk);
    go <= 0;
    {ea, eb, ec, ed} = {ea[2:0], b[3], eb[3:0], b[2], ec[2:0], b[1], ed[3:0], b[0]};
    @(negedge i_clk);
    while (busy) @(negedge i_clk);
  endtask
  task t_chain;
    logic x;
    for (int i = 0; i < 20; i++)
    begin
      x = pat[i];
      hist = {hist[16:0], x};
      shift({x, st.out_a, st.out_b, st.out_c});
      chk("stage", st, ex());
      if (i > 16) chk("chain", {5'h00, st.out_d}, {5'h00, hist[17]});
    end
    $display("chain done");
  endtask
  task t_shift;
    for (int i = 0; i < 12; i++)
    begin
      shift(4'(i * 7 + 3));
      if (i > 4) chk("stage", st, ex());
    end
    $display("shift done");
  endtask
  task t_hold;
    repeat (60) @(posedge i_clk);
    @(negedge i_clk);
    chk("hold", st, ex());
    @(posedge i_clk);
    i_srst <= 1;
    repeat (3) @(posedge i_clk);
    i_srst <= 0;
    @(negedge i_clk);
    chk("reset", st, ex());
    chk("valid", {5'h00, sv}, 6'h00);
    $display("hold done");
  endtask
  task t_buf;
    @(posedge i_clk);
    rdy <= 0;
    shift(4'h5);
    e1 = ex();
    shift(4'ha);
    e2 = ex();
    shift(4'hf);
    chk("snap1", sn, e1);
    @(posedge i_clk);
    rdy <= 1;
    @(posedge i_clk);
    rdy <= 0;
    @(negedge i_clk);
    chk("snap2", sn, e2);
    @(posedge i_clk);
    rdy <= 1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("drained", {5'h00, sv}, 6'h00);
    $display("buffer done");
  endtask
  task close_out;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    i_srst <= 0;
    t_shift;
    t_chain;
    t_hold;
    t_buf;
    close_out;
  end
endmodule
